// >>> hdl/sbdm_pkg.sv
// constants and carrier types of the system bus dma master
package sbdm_pkg;
   // ---------------------------------------------------------------
   // register indices of the programming port
   // ---------------------------------------------------------------
   localparam logic [2:0] REG_MODE      = 3'h0;
   localparam logic [2:0] REG_ADDR_LO   = 3'h1;
   localparam logic [2:0] REG_ADDR_HI   = 3'h2;
   localparam logic [2:0] REG_HIGH_ADDR = 3'h3;
   localparam logic [2:0] REG_CNT_LO    = 3'h4;
   localparam logic [2:0] REG_CNT_HI    = 3'h5;
   localparam logic [2:0] REG_GSR       = 3'h6;
   // ---------------------------------------------------------------
   // field positions and encodings
   // ---------------------------------------------------------------
   localparam int         MODE_TT_LSB   = 2;
   localparam int         MODE_LVL_LSB  = 4;
   localparam logic [1:0] TT_SINGLE     = 2'h0;
   localparam logic [1:0] TT_DEMAND     = 2'h1;
   localparam int         GSR_TMO_BIT   = 0;
   localparam int         GSR_ACT_BIT   = 1;
   localparam int         GSR_EVT_BIT   = 2;
   localparam logic [7:0] MODE_RST      = 8'h0C;
   localparam logic [7:0] HIGH_RST      = 8'h00;
   // ---------------------------------------------------------------
   // timing and sizes
   // ---------------------------------------------------------------
   localparam int         CLK_NS        = 40;
   localparam int         TIMEOUT_NS    = 1600000;
   localparam int         TIMEOUT_CYC   = TIMEOUT_NS / CLK_NS;
   localparam int         BYTE_W        = 8;
   localparam int         FIFO_DEPTH    = 8;
   // ---------------------------------------------------------------
   // states and carriers
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01, ST_REQ = 5'h02, ST_OWN = 5'h04, ST_CYC = 5'h08, ST_DROP = 5'h10
   } dma_state_t;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] sel;
      logic [7:0] wdata;
   } reg_req_t;
   typedef struct packed {
      logic busy;
      logic prio_in;
      logic lock;
      logic preempt;
   } arb_in_t;
   typedef struct packed {
      logic [23:0] adr;
      logic [15:0] dat;
      logic        mem_wr;
      logic        bhen;
   } bus_cmd_t;
endpackage : sbdm_pkg

// >>> hdl/system_bus_dma_master.sv
// byte fifo and dma bus master of the system bus adapter
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input  wire logic         sys_clk_i,
   input  wire logic         rst_b_i,
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         n;
   } fifo_t;
   fifo_t s, next_s;
   logic  push, pop;
   // ---------------------------------------------------------------
   // handshakes and pointer update
   // ---------------------------------------------------------------
   assign in_ready_o  = (s.n != (AW+1)'(D));
   assign out_valid_o = (s.n != '0);
   assign out_data_o  = s.mem[s.rp];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wp] = in_data_i;
         next_s.wp        = (s.wp == AW'(D-1)) ? '0 : s.wp + 1'b1;
      end
      if (pop) begin
         next_s.rp = (s.rp == AW'(D-1)) ? '0 : s.rp + 1'b1;
      end
      next_s.n = s.n + (AW+1)'(push) - (AW+1)'(pop);
   end
   // state register
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) s <= '0;
      else          s <= next_s;
   end
endmodule : byte_fifo

// Contract
// - while owning the bus, all interrupt request lines stay quiet
// - bus request and common bus request are asserted together
// - a forced release re-requests the bus alone and resumes the transfer
// - base and current address are 16 bits, wrapping without carry upward
// - single-byte or demand mode bursts bytes until the count runs out
// - 8-bit data, copied onto both lanes of a 16-bit bus
// - programming is accepted whenever hold grant is low
// - high address register drives address bits 16 to 23
// - on each bus grant the middle address byte is latched from the address counter
// - any set status flag raises an interrupt request
// - a switch picks serial or parallel priority resolution
// - eight interrupt outputs driven, interrupt acknowledge taken as input
// - a byte cycle past 1.6 ms sets the timeout flag and goes on
// - bus taken only when requesting, free, prioritised and not locked
// - serial priority passes down the daisy chain of masters
module system_bus_dma_master
   import sbdm_pkg::*;
#(
   parameter int TMO_CYC = TIMEOUT_CYC
) (
   input  wire logic             sys_clk_i,
   input  wire logic             rst_b_i,
   input  wire reg_req_t         reg_i,
   output logic [7:0]            reg_rdata_o,
   input  wire logic             scsi_valid_i,
   input  wire logic [BYTE_W-1:0] scsi_data_i,
   output logic                  scsi_ready_o,
   input  wire logic             scsi_event_i,
   input  wire logic             arbitration_select_switch_i,
   input  wire arb_in_t          arb_i,
   output logic                  bus_req_o,
   output logic                  common_bus_req_o,
   output logic                  bus_prio_out_o,
   output logic                  hold_request_o,
   output logic                  hold_grant_o,
   output bus_cmd_t              bus_cmd_o,
   input  wire logic             xack_i,
   output logic [7:0]            int_req_o,
   input  wire logic             int_ack_i
);
   localparam int TW = $clog2(TMO_CYC + 1);
   typedef struct packed {
      dma_state_t  st;
      logic [7:0]  mode;
      logic [15:0] base;
      logic [15:0] cur;
      logic [7:0]  dma_high_address;
      logic [15:0] cnt;
      logic [7:0]  adr_mid;
      logic [1:0]  flags;
      logic [7:0]  rdata;
      logic [7:0]  irq;
      logic [TW-1:0] tmo;
      bus_cmd_t    cmd;
   } dma_t;
   dma_t        s, next_s;
   logic        fifo_valid, fifo_pop, tt_ok, grant, free_ok;
   logic [7:0]  fifo_data;
   logic [2:0]  general_status_reg;
   // ---------------------------------------------------------------
   // data buffer from the scsi side
   // ---------------------------------------------------------------
   byte_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_fifo (
      .sys_clk_i   (sys_clk_i),
      .rst_b_i     (rst_b_i),
      .in_valid_i  (scsi_valid_i),
      .in_data_i   (scsi_data_i),
      .in_ready_o  (scsi_ready_o),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_data)
   );
   // ---------------------------------------------------------------
   // arbitration and status terms
   // ---------------------------------------------------------------
   assign grant          = (s.st == ST_OWN) || (s.st == ST_CYC);
   assign hold_grant_o   = grant;
   assign hold_request_o = (s.st == ST_REQ) || grant;
   assign bus_req_o        = hold_request_o;
   assign common_bus_req_o = hold_request_o;
   // serial chain passes priority on only while not requesting the bus
   assign bus_prio_out_o = arbitration_select_switch_i
                           && arb_i.prio_in && !hold_request_o;
   assign free_ok  = arb_i.prio_in && !arb_i.busy && !arb_i.lock;
   assign tt_ok    = (s.mode[MODE_TT_LSB +: 2] == TT_SINGLE)
                     || (s.mode[MODE_TT_LSB +: 2] == TT_DEMAND);
   assign fifo_pop = (s.st == ST_OWN) && !arb_i.preempt && (s.cnt != 16'h0000);
   assign general_status_reg = {s.flags[1], (s.st != ST_IDLE), s.flags[0]};
   assign reg_rdata_o = s.rdata;
   assign bus_cmd_o   = s.cmd;
   assign int_req_o   = s.irq;
   // ---------------------------------------------------------------
   // next state of registers and sequencer
   // ---------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.cmd.mem_wr = 1'b0;
      // programming only while the cpu still owns the bus
      if (reg_i.wr && !grant) begin
         unique case (reg_i.sel)
            REG_MODE:      next_s.mode = reg_i.wdata;
            REG_ADDR_LO: begin
               next_s.base[7:0] = reg_i.wdata;
               next_s.cur[7:0]  = reg_i.wdata;
            end
            REG_ADDR_HI: begin
               next_s.base[15:8] = reg_i.wdata;
               next_s.cur[15:8]  = reg_i.wdata;
            end
            REG_HIGH_ADDR: next_s.dma_high_address = reg_i.wdata;
            REG_CNT_LO:    next_s.cnt[7:0]  = reg_i.wdata;
            REG_CNT_HI:    next_s.cnt[15:8] = reg_i.wdata;
            default:       ;
         endcase
      end
      // read data; a status read clears the sticky flags
      if (reg_i.rd) begin
         unique case (reg_i.sel)
            REG_MODE:      next_s.rdata = s.mode;
            REG_ADDR_LO:   next_s.rdata = s.cur[7:0];
            REG_ADDR_HI:   next_s.rdata = s.cur[15:8];
            REG_HIGH_ADDR: next_s.rdata = s.dma_high_address;
            REG_CNT_LO:    next_s.rdata = s.cnt[7:0];
            REG_CNT_HI:    next_s.rdata = s.cnt[15:8];
            REG_GSR: begin
               next_s.rdata = {5'h00, general_status_reg};
               next_s.flags = 2'h0;
            end
            default:       next_s.rdata = 8'h00;
         endcase
      end
      if (int_ack_i) next_s.flags[1] = 1'b0;
      if (scsi_event_i) next_s.flags[1] = 1'b1;  // set wins over clear
      unique case (s.st)
         ST_IDLE: begin
            // re-arm by itself once nobody forces us off
            if (s.cnt != 16'h0000 && tt_ok && !arb_i.preempt) next_s.st = ST_REQ;
         end
         ST_REQ: begin
            if (free_ok) begin
               next_s.st      = ST_OWN;
               next_s.adr_mid = s.cur[15:8];
            end
         end
         ST_OWN: begin
            if (arb_i.preempt || s.cnt == 16'h0000) begin
               next_s.st = ST_DROP;
            end else if (fifo_valid) begin
               next_s.st         = ST_CYC;
               next_s.tmo        = '0;
               next_s.cmd.adr    = {s.dma_high_address, s.adr_mid, s.cur[7:0]};
               next_s.cmd.dat    = {fifo_data, fifo_data};
               next_s.cmd.bhen   = 1'b0;
               next_s.cmd.mem_wr = 1'b1;
            end
         end
         ST_CYC: begin
            next_s.cmd.mem_wr = 1'b1;
            next_s.tmo        = s.tmo + 1'b1;
            if (xack_i || s.tmo == TW'(TMO_CYC - 1)) begin
               if (!xack_i) next_s.flags[0] = 1'b1;
               next_s.cmd.mem_wr = 1'b0;
               next_s.st  = ST_OWN;
               next_s.cur = s.cur + 16'h0001;
               next_s.cnt = s.cnt - 16'h0001;
               if (s.cur[7:0] == 8'hFF) next_s.adr_mid = s.adr_mid + 8'h01;
            end
         end
         ST_DROP: next_s.st = ST_IDLE;
      endcase
      // interrupt line chosen by mode, silenced while owning the bus
      next_s.irq = 8'h00;
      if (next_s.flags != 2'h0 && next_s.st != ST_OWN && next_s.st != ST_CYC) begin
         next_s.irq = 8'h01 << next_s.mode[MODE_LVL_LSB +: 3];
      end
   end
   // state register
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s                  <= '0;
         s.st               <= ST_IDLE;
         s.mode             <= MODE_RST;
         s.dma_high_address <= HIGH_RST;
      end else begin
         s <= next_s;
      end
   end
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence took_bus_s;
      $rose(grant);
   endsequence
   // idle with work left and nobody forcing us off: the request must follow
   sequence forced_off_s;
      s.st == ST_IDLE && s.cnt != 16'h0000 && tt_ok && !arb_i.preempt;
   endsequence
   a_irq_held_off: assert property (grant |-> int_req_o == 8'h00)
      else $error("interrupt line active while owning the bus");
   a_both_requests: assert property (bus_req_o == common_bus_req_o)
      else $error("bus request lines disagree");
   a_resume_request: assert property (forced_off_s |=> bus_req_o)
      else $error("no re-request after forced release");
   a_addr_wrap: assert property (s.st == ST_CYC && xack_i && s.cur == 16'hFFFF
      |=> s.cur == 16'h0000 && $stable(s.dma_high_address))
      else $error("address counter carried past 16 bits");
   a_burst_start: assert property (s.st == ST_OWN && fifo_valid && !arb_i.preempt
      && s.cnt != 16'h0000 |=> bus_cmd_o.mem_wr && bus_cmd_o.dat[7:0] == $past(fifo_data))
      else $error("pending byte not issued");
   a_byte_lanes: assert property (bus_cmd_o.mem_wr
      |-> bus_cmd_o.dat[15:8] == bus_cmd_o.dat[7:0] && !bus_cmd_o.bhen)
      else $error("byte not on both lanes");
   a_prog_accept: assert property (reg_i.wr && reg_i.sel == REG_MODE && !grant
      |=> s.mode == $past(reg_i.wdata))
      else $error("mode write lost");
   a_high_addr: assert property (bus_cmd_o.mem_wr
      |-> bus_cmd_o.adr[23:16] == s.dma_high_address)
      else $error("upper address not from high address register");
   a_mid_latch: assert property (took_bus_s |-> s.adr_mid == $past(s.cur[15:8]))
      else $error("middle address byte not latched at grant");
   a_flag_irq: assert property (s.flags != 2'h0 && !grant |-> int_req_o != 8'h00)
      else $error("flag set without interrupt");
   a_timeout_set: assert property (s.st == ST_CYC && !xack_i && s.tmo == TW'(TMO_CYC - 1)
      |=> s.flags[0] && s.st == ST_OWN)
      else $error("timeout flag not set");
   a_take_cond: assert property (took_bus_s
      |-> $past(free_ok && bus_req_o))
      else $error("bus taken without free priority");
   a_chain_block: assert property (hold_request_o |-> !bus_prio_out_o)
      else $error("priority passed on while requesting");
   a_release_done: assert property (s.st == ST_OWN && s.cnt == 16'h0000
      |=> !grant ##1 !bus_req_o)
      else $error("bus kept after completion");

   // ---------------------------------------------------------------
   // checks on status, interrupts, counting and arbitration
   // ---------------------------------------------------------------
   sequence status_read_s;
      reg_i.rd && reg_i.sel == REG_GSR && !scsi_event_i;
   endsequence
   sequence slot_done_s;
      s.st == ST_CYC && xack_i;
   endsequence
   sequence preempt_s;
      s.st == ST_OWN && arb_i.preempt;
   endsequence

   // a status read returns the flags and clears the event flag
   a_status_data: assert property (reg_i.rd && reg_i.sel == REG_GSR
      |=> reg_rdata_o == {5'h00, $past(general_status_reg)})
      else $error("status read data wrong");
   a_status_clear: assert property (status_read_s |=> !s.flags[1])
      else $error("status read left event flag set");
   // event input sets its flag, acknowledge clears it
   a_event_set: assert property (scsi_event_i |=> s.flags[1])
      else $error("event flag not set");
   a_ack_clear: assert property (int_ack_i && !scsi_event_i |=> !s.flags[1])
      else $error("acknowledge did not clear event flag");
   // only one interrupt line at a time
   a_one_line: assert property (int_req_o != 8'h00 |-> $onehot(int_req_o))
      else $error("more than one interrupt line active");

   // every acknowledged byte counts down once
   a_byte_count: assert property (slot_done_s |=> s.cnt == $past(s.cnt) - 16'h0001)
      else $error("byte count not decremented");
   // middle address byte steps when the low byte wraps
   a_mid_carry: assert property (slot_done_s && s.cur[7:0] == 8'hFF
      |=> s.adr_mid == $past(s.adr_mid) + 8'h01)
      else $error("middle address byte did not step");
   // an illegal transfer type never leaves idle
   a_no_start: assert property (s.st == ST_IDLE && !tt_ok |=> s.st == ST_IDLE)
      else $error("started with illegal transfer type");
   // writes while owning the bus are dropped
   a_wr_ignored: assert property (reg_i.wr && reg_i.sel == REG_HIGH_ADDR && grant
      |=> $stable(s.dma_high_address))
      else $error("register written while owning the bus");

   // parallel priority keeps the chain output quiet
   a_par_quiet: assert property (!arbitration_select_switch_i |-> !bus_prio_out_o)
      else $error("priority out driven in parallel mode");
   // forced off: drop, go idle, then re-request by itself
   a_preempt_drop: assert property (preempt_s |=> s.st == ST_DROP ##1 s.st == ST_IDLE)
      else $error("forced release not taken");
   a_drop_release: assert property (s.st == ST_DROP
      |-> !bus_req_o && !common_bus_req_o && !grant)
      else $error("requests still up while dropping the bus");
endmodule : system_bus_dma_master
`default_nettype wire

// >>> testbench/host_memory_model.sv
// host memory model that acknowledges dma byte writes on the system bus
`timescale 1ns/1ns
`default_nettype none
module host_memory_model
   import sbdm_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       rst_b_i,
   input  wire bus_cmd_t   bus_cmd_i,
   input  wire logic [7:0] ack_delay_i,
   output logic            xack_o
);
   logic [7:0] mem [logic [23:0]];
   int         n_wr     = 0;
   int         lane_err = 0;
   logic [7:0] wait_cnt;
   // ---------------------------------------------------------------
   // memory write cycle: wait the set delay, store the byte, acknowledge
   // ---------------------------------------------------------------
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         xack_o   <= 1'b0;
         wait_cnt <= 8'h00;
      end else if (bus_cmd_i.mem_wr && !xack_o) begin
         if (wait_cnt >= ack_delay_i) begin
            xack_o <= 1'b1;
            mem[bus_cmd_i.adr] = bus_cmd_i.dat[7:0];
            n_wr++;
            // both lanes carry the byte, high enable stays off
            if (bus_cmd_i.dat[15:8] !== bus_cmd_i.dat[7:0] || bus_cmd_i.bhen !== 1'b0) lane_err++;
         end else begin
            wait_cnt <= wait_cnt + 8'h01;
         end
      end else begin
         xack_o   <= 1'b0; // released acknowledge reads as not ready
         wait_cnt <= 8'h00;
      end
   end
endmodule : host_memory_model
`default_nettype wire

// >>> testbench/system_bus_dma_master_bench.sv
// self-checking bench of the system bus dma master
`timescale 1ns/1ns
`default_nettype none
`define CMP(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module system_bus_dma_master_bench import sbdm_pkg::*;;
   logic sys_clk = 1'b0, rst_b = 1'b0, sv = 1'b0, evt = 1'b0, sw = 1'b0, iack = 1'b0;
   logic srdy, breq, cbrq, pout, hreq, hgnt, xack;
   reg_req_t   reg_r = '0;
   arb_in_t    arb = '{busy: 1'b0, prio_in: 1'b1, lock: 1'b0, preempt: 1'b0};
   bus_cmd_t   cmd;
   logic [7:0] rdata, irq, hi, v, sd = 8'h00, dly = 8'h00;
   logic [15:0] base;
   logic [7:0] q[$];
   int         failures = 0, n_compared = 0, cyc = 0, n0 = 0, n;
   system_bus_dma_master #(.TMO_CYC(20)) system_bus_dma_master_inst (
      .sys_clk_i(sys_clk), .rst_b_i(rst_b), .reg_i(reg_r), .reg_rdata_o(rdata),
      .scsi_valid_i(sv), .scsi_data_i(sd), .scsi_ready_o(srdy), .scsi_event_i(evt),
      .arbitration_select_switch_i(sw), .arb_i(arb), .bus_req_o(breq),
      .common_bus_req_o(cbrq), .bus_prio_out_o(pout), .hold_request_o(hreq),
      .hold_grant_o(hgnt), .bus_cmd_o(cmd), .xack_i(xack), .int_req_o(irq),
      .int_ack_i(iack));
   host_memory_model mdl (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .bus_cmd_i(cmd),
      .ack_delay_i(dly), .xack_o(xack));
   // ---------------------------------------------------------------
   // clock, watchdog and closing report
   // ---------------------------------------------------------------
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   task tally_and_finish;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         tally_and_finish();
      end
   end
   // both requests follow hold request; interrupts quiet while owning
   always @(negedge sys_clk) begin
      if (rst_b) begin
         `CMP("bus_req", hreq, breq)
         `CMP("common_req", hreq, cbrq)
         if (hgnt === 1'b1) `CMP("irq_owned", 8'h00, irq)
      end
   end
   // ---------------------------------------------------------------
   // register port and transfer tasks
   // ---------------------------------------------------------------
   task wr(input logic [2:0] s, input logic [7:0] d);
      @(posedge sys_clk) reg_r <= '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
      @(posedge sys_clk) reg_r.wr <= 1'b0;
   endtask : wr
   task chk_rd(input string nm, input logic [2:0] s, input logic [7:0] e);
      @(posedge sys_clk) reg_r <= '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 8'h00};
      @(posedge sys_clk) reg_r.rd <= 1'b0;
      #1 `CMP(nm, e, rdata)
   endtask : chk_rd
   task go(input logic [1:0] tt, input logic [2:0] lvl);
      logic [7:0] b8;
      wr(REG_MODE, {1'b0, lvl, 2'b11, 2'b00});
      wr(REG_HIGH_ADDR, hi);
      wr(REG_ADDR_LO, base[7:0]);
      wr(REG_ADDR_HI, base[15:8]);
      wr(REG_CNT_LO, 8'(n));
      wr(REG_CNT_HI, 8'h00);
      q.delete();
      for (int i = 0; i < n; i++) begin
         b8 = 8'($urandom);
         @(posedge sys_clk) sv <= 1'b1;
         sd <= b8;
         q.push_back(b8);
      end
      @(posedge sys_clk) sv <= 1'b0;
      #1 if (n == 8) `CMP("fifo_full", 1'b0, srdy)
      n0 = mdl.n_wr;
      wr(REG_MODE, {1'b0, lvl, tt, 2'b00});
   endtask : go
   task fin;
      logic [15:0] a;
      for (int k = 0; k < 3000 && mdl.n_wr < n0 + n; k++) @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
      #1 `CMP("released", 1'b0, hreq)
      for (int i = 0; i < n; i++) begin
         a = base + 16'(i);
         `CMP("mem", q[i], mdl.mem[{hi, a}])
      end
   endtask : fin
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      v = 8'($urandom(85463));
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      chk_rd("mode_rst", REG_MODE, MODE_RST);
      chk_rd("high_rst", REG_HIGH_ADDR, HIGH_RST);
      chk_rd("gsr_rst", REG_GSR, 8'h00);
      chk_rd("unmapped", 3'h7, 8'h00);
      `CMP("prio_par", 1'b0, pout)
      @(posedge sys_clk) sw <= 1'b1;
      @(posedge sys_clk) #1 `CMP("prio_ser", 1'b1, pout)
      // random transfers of both types, first one wraps the 16-bit counter
      for (int t = 0; t < 4; t++) begin
         dly <= 8'($urandom % 4);
         hi = 8'($urandom);
         base = (t == 0) ? 16'hFFFC : (16'($urandom) & 16'hFFF7);
         n = (t == 0) ? 4 : 1 + $urandom % 8;
         go(t[0] ? TT_DEMAND : TT_SINGLE, 3'h0);
         fin();
      end
      // bus busy, locked, then lower priority: no grant; reprogram while waiting
      arb.busy <= 1'b1;
      go(TT_SINGLE, 3'h0);
      repeat (10) @(posedge sys_clk);
      #1 `CMP("grant_busy", 1'b0, hgnt)
      `CMP("prio_pass", 1'b0, pout)
      hi = ~hi;
      wr(REG_HIGH_ADDR, hi);
      arb <= '{busy: 1'b0, prio_in: 1'b1, lock: 1'b1, preempt: 1'b0};
      repeat (10) @(posedge sys_clk);
      #1 `CMP("grant_lock", 1'b0, hgnt)
      arb <= '{busy: 1'b0, prio_in: 1'b0, lock: 1'b0, preempt: 1'b0};
      repeat (10) @(posedge sys_clk);
      #1 `CMP("grant_prio", 1'b0, hgnt)
      arb.prio_in <= 1'b1;
      fin();
      // forced off mid-transfer with a slow memory, then resumed unaided
      dly <= 8'h03;
      n = 8;
      go(TT_DEMAND, 3'h0);
      for (int k = 0; k < 200 && !hgnt; k++) @(posedge sys_clk);
      repeat (9) @(posedge sys_clk);
      arb.preempt <= 1'b1;
      repeat (8) @(posedge sys_clk);
      #1 `CMP("preempt_grant", 1'b0, hgnt)
      arb.preempt <= 1'b0;
      fin();
      // memory never answers: timeout flag, transfer still ends
      dly <= 8'd100;
      n = 1;
      go(TT_SINGLE, 3'h0);
      for (int k = 0; k < 50 && !hgnt; k++) @(posedge sys_clk);
      evt <= 1'b1;
      @(posedge sys_clk) evt <= 1'b0;
      repeat (60) @(posedge sys_clk);
      #1 `CMP("tmo_release", 1'b0, hreq)
      `CMP("irq_after", 8'h01, irq)
      chk_rd("gsr_tmo", REG_GSR, 8'h05);
      chk_rd("gsr_clr", REG_GSR, 8'h00);
      // every interrupt line: raise by event, clear by acknowledge
      dly <= 8'h00;
      for (int l = 0; l < 8; l++) begin
         wr(REG_MODE, {1'b0, 3'(l), 2'b11, 2'b00});
         @(posedge sys_clk) evt <= 1'b1;
         @(posedge sys_clk) evt <= 1'b0;
         repeat (2) @(posedge sys_clk);
         #1 `CMP("irq_line", 8'h01 << l, irq)
         @(posedge sys_clk) iack <= 1'b1;
         @(posedge sys_clk) iack <= 1'b0;
         repeat (2) @(posedge sys_clk);
         #1 `CMP("irq_ack", 8'h00, irq)
      end
      `CMP("lanes", 0, mdl.lane_err)
      tally_and_finish();
   end
endmodule : system_bus_dma_master_bench
`default_nettype wire
